// ### rtl/smic_i2c_slave.sv
// serial control bus slave: address match, register pointer, auto-increment
// assumes scl and sda arrive already synchronised to clk
`timescale 1ns/100ps
module smic_i2c_slave (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register side
  smic_reg_if.slave bus
);
  smic_pkg::smic_slv_state_t state;
  logic scl_q;
  logic sda_q;
  logic byte_done;
  logic first;
  logic rw;
  logic nack;
  logic wr_stb;
  logic pull;
  logic [2:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] ptr;
  logic [7:0] wdata;
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;
  wire addr_hit;

  // bus conditions from the sampled lines
  assign scl_rise = bus.scl & ~scl_q;
  assign scl_fall = ~bus.scl & scl_q;
  assign start_seen = bus.scl & scl_q & sda_q & ~bus.sda;
  assign stop_seen = bus.scl & scl_q & ~sda_q & bus.sda;
  assign addr_hit = shreg[7:1] == smic_pkg::DEV_ADDR;
  assign bus.wr_stb = wr_stb;
  assign bus.ptr = ptr;
  assign bus.wdata = wdata;
  assign bus.pull = pull;

  // previous line levels for edge detection
  always_ff @(posedge clk) begin
    scl_q <= bus.scl;
    sda_q <= bus.sda;
  end

  // byte engine; pull means drive sda low
  always_ff @(posedge clk) begin
    wr_stb <= 1'b0;
    if (srst) begin
      state <= smic_pkg::SLV_IDLE;
      pull <= 1'b0;
      byte_done <= 1'b0;
      bitcnt <= 3'h7;
      shreg <= 8'h00;
      ptr <= 8'h00;
      wdata <= 8'h00;
      first <= 1'b0;
      rw <= 1'b0;
      nack <= 1'b0;
    end else if (bus.bus_reset || stop_seen) begin
      state <= smic_pkg::SLV_IDLE;
      pull <= 1'b0;
    end else if (start_seen) begin
      state <= smic_pkg::SLV_ADDR;
      pull <= 1'b0;
      byte_done <= 1'b0;
      bitcnt <= 3'h7;
    end else begin
      // pointer advances the cycle after each stored byte
      if (wr_stb) begin
        ptr <= ptr + 8'h01;
      end
      case (state)
        smic_pkg::SLV_ADDR, smic_pkg::SLV_WR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], bus.sda};
            byte_done <= bitcnt == 3'h0;
            bitcnt <= bitcnt - 3'h1;
          end else if (scl_fall && byte_done) begin
            byte_done <= 1'b0;
            if (state == smic_pkg::SLV_ADDR) begin
              pull <= addr_hit;
              rw <= shreg[0];
              first <= 1'b1;
              state <= addr_hit ? smic_pkg::SLV_ACK_A : smic_pkg::SLV_IDLE;
            end else begin
              pull <= 1'b1;
              state <= smic_pkg::SLV_ACK_W;
              first <= 1'b0;
              if (first) begin
                ptr <= shreg;
              end else begin
                wr_stb <= 1'b1;
                wdata <= shreg;
              end
            end
          end
        end
        smic_pkg::SLV_ACK_A, smic_pkg::SLV_ACK_R: begin
          if (scl_rise) begin
            nack <= bus.sda;
          end else if (scl_fall) begin
            // master nack ends a read; a write address ack goes to SLV_WR; else load the next byte
            if (state == smic_pkg::SLV_ACK_R && nack) begin
              pull <= 1'b0;
              state <= smic_pkg::SLV_IDLE;
            end else if (state == smic_pkg::SLV_ACK_A && !rw) begin
              pull <= 1'b0;
              state <= smic_pkg::SLV_WR;
            end else begin
              shreg <= bus.rdata;
              pull <= ~bus.rdata[7];
              ptr <= ptr + 8'h01;
              bitcnt <= 3'h7;
              state <= smic_pkg::SLV_RD;
            end
          end
        end
        smic_pkg::SLV_ACK_W: begin
          if (scl_fall) begin
            pull <= 1'b0;
            state <= smic_pkg::SLV_WR;
          end
        end
        smic_pkg::SLV_RD: begin
          if (scl_fall) begin
            if (bitcnt == 3'h0) begin
              pull <= 1'b0;
              state <= smic_pkg::SLV_ACK_R;
            end else begin
              pull <= ~shreg[6];
              shreg <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt - 3'h1;
            end
          end
        end
        default: begin
          pull <= 1'b0;
        end
      endcase
    end
  end
endmodule : smic_i2c_slave

// ### rtl/smic_pkg.sv
// constants, types and register map of the link mode and bus control bank
// assumes a single 50 MHz clock and a synchronous active-high reset
package smic_pkg;
  // register offsets
  localparam logic [7:0] MODE_ADDR = 8'h04;
  localparam logic [7:0] CTRL_ADDR = 8'h05;
  localparam logic [7:0] CRC_LO_ADDR = 8'h0a;
  localparam logic [7:0] CRC_HI_ADDR = 8'h0b;
  // reset values and writable bits
  localparam logic [7:0] MODE_RESET = 8'h80;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'hbf;
  localparam logic [7:0] CTRL_WMASK = 8'h1f;
  // mode register fields
  localparam int FAILSAFE_BIT = 7;
  localparam int CRC_CLEAR_BIT = 5;
  localparam int GATE_BIT = 4;
  localparam int LEGACY_SRC_BIT = 3;
  localparam int LEGACY_BIT = 2;
  localparam int RANGE_SRC_BIT = 1;
  localparam int RANGE_BIT = 0;
  // control register fields
  localparam int DLY_HI_BIT = 4;
  localparam int DLY_LO_BIT = 3;
  localparam int BLOCK_BIT = 2;
  localparam int SPEED_BIT = 1;
  localparam int WD_DIS_BIT = 0;
  // own bus address, arbitrary value
  localparam logic [6:0] DEV_ADDR = 7'h1a;
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int DLY_BASE_NS = 240;
  localparam int DLY_STEP_NS = 40;
  localparam int DLY_BASE_CYCLES = DLY_BASE_NS / CLK_PERIOD_NS;
  localparam int DLY_STEP_CYCLES = DLY_STEP_NS / CLK_PERIOD_NS;
  localparam int DLY_TAPS = 18;
  localparam int WDOG_LONG_S = 1;
  localparam int WDOG_FAST_US = 50;
  localparam int WDOG_LONG_CYCLES = WDOG_LONG_S * CLK_HZ;
  localparam int WDOG_FAST_CYCLES = WDOG_FAST_US * (CLK_HZ / 1_000_000);
  localparam int CLR_HALF_NS = 5000;
  localparam int CLR_HALF_CYCLES = CLR_HALF_NS / CLK_PERIOD_NS;
  localparam int CLR_PULSES = 9;
  // state types
  typedef enum logic [2:0] {
    SLV_IDLE = 3'b000, SLV_ADDR = 3'b001, SLV_ACK_A = 3'b010, SLV_WR = 3'b011,
    SLV_ACK_W = 3'b100, SLV_RD = 3'b101, SLV_ACK_R = 3'b110
  } smic_slv_state_t;
  typedef enum logic [0:0] {WD_WATCH = 1'b0, WD_CLEAR = 1'b1} smic_wd_state_t;
endpackage : smic_pkg

// ### rtl/smic_reg_if.sv
// register access group between the serial bus slave and the register bank
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface smic_reg_if;
  logic scl;
  logic sda;
  logic bus_reset;
  logic [7:0] rdata;
  logic wr_stb;
  logic [7:0] ptr;
  logic [7:0] wdata;
  logic pull;
  modport slave (input scl, sda, bus_reset, rdata, output wr_stb, ptr, wdata, pull);
  modport bank (output scl, sda, bus_reset, rdata, input wr_stb, ptr, wdata, pull);
endinterface : smic_reg_if

// ### rtl/smic_top.sv
// link mode and serial bus control bank with bus watchdog and pixel gating
// assumes pixel data and error pulses are synchronous to REF_CLK
`timescale 1ns/100ps
module smic_top #(
  parameter int WDOG_LONG_CYCLES = smic_pkg::WDOG_LONG_CYCLES
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // serial control bus pins
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic BUS_FREE,
  // mode pins and mode outputs
  input wire logic LEGACY_PAIRING_PIN,
  input wire logic CLOCK_RANGE_PIN,
  output logic FAILSAFE_LOW,
  output logic LEGACY_MODE,
  output logic CLOCK_RANGE_LOW,
  // back-channel error events
  input wire logic CRC_ERROR,
  // pixel path
  input wire logic PARTNER_PROTECTED,
  input wire logic DATA_ENABLE,
  input wire logic [23:0] PIXEL_IN,
  output logic [23:0] PIXEL_OUT,
  // remote writes from the control channel
  input wire logic REM_WR_VALID,
  output logic REM_WR_READY,
  input wire logic REM_WR_LOCAL,
  input wire logic [7:0] REM_WR_ADDR,
  input wire logic [7:0] REM_WR_DATA,
  output logic REM_WR_REJECT,
  output logic REM_FWD_VALID,
  output logic [7:0] REM_FWD_ADDR,
  output logic [7:0] REM_FWD_DATA
);
  smic_reg_if bus ();
  logic [3:0] meta;
  logic [3:0] sync;
  logic [7:0] reg_mode;
  logic [7:0] reg_ctrl;
  logic [15:0] crc_cnt;
  logic scl_p;
  logic sda_p;
  smic_pkg::smic_wd_state_t wd_state;
  logic [25:0] wd_cnt;
  logic [7:0] half_cnt;
  logic [3:0] pulses;
  logic [smic_pkg::DLY_TAPS-1:0] sda_dly;
  wire [3:0] pins_raw;
  wire scl_s;
  wire sda_s;
  wire legacy_pin_s;
  wire range_pin_s;

  // two-flop synchronisers for the serial bus and mode pin inputs
  assign pins_raw = {CLOCK_RANGE_PIN, LEGACY_PAIRING_PIN, SDA_IN, SCL_IN};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge REF_CLK) begin
        meta[gi] <= pins_raw[gi];
        sync[gi] <= meta[gi];
      end
    end
  endgenerate
  assign scl_s = sync[0];
  assign sda_s = sync[1];
  assign legacy_pin_s = sync[2];
  assign range_pin_s = sync[3];
  assign bus.scl = scl_s;
  assign bus.sda = sda_s;

  smic_i2c_slave u_slave (
    .clk (REF_CLK),
    .srst (SRST),
    .bus (bus.slave)
  );

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  // write source select; local bus master has priority over remote
  wire rem_take;
  wire rem_local_ok;
  wire wr_en;
  wire [7:0] wr_addr;
  wire [7:0] wr_data;
  wire wr_mode;
  wire wr_ctrl;
  assign REM_WR_READY = ~bus.wr_stb;
  assign rem_take = REM_WR_VALID & REM_WR_READY;
  assign rem_local_ok = rem_take & REM_WR_LOCAL & ~reg_ctrl[smic_pkg::BLOCK_BIT];
  assign wr_en = bus.wr_stb | rem_local_ok;
  assign wr_addr = bus.wr_stb ? bus.ptr : REM_WR_ADDR;
  assign wr_data = bus.wr_stb ? bus.wdata : REM_WR_DATA;
  assign wr_mode = wr_en && wr_addr == smic_pkg::MODE_ADDR;
  assign wr_ctrl = wr_en && wr_addr == smic_pkg::CTRL_ADDR;

  // configuration registers; reserved bits masked off on write
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      reg_mode <= smic_pkg::MODE_RESET;
      reg_ctrl <= smic_pkg::CTRL_RESET;
    end else begin
      if (wr_mode) begin
        reg_mode <= wr_data & smic_pkg::MODE_WMASK;
      end
      if (wr_ctrl) begin
        reg_ctrl <= wr_data & smic_pkg::CTRL_WMASK;
      end
    end
  end

  // read mux; error count is live, not snapshotted across bytes
  assign bus.rdata = (bus.ptr == smic_pkg::MODE_ADDR) ? reg_mode :
                     (bus.ptr == smic_pkg::CTRL_ADDR) ? reg_ctrl :
                     (bus.ptr == smic_pkg::CRC_LO_ADDR) ? crc_cnt[7:0] :
                     (bus.ptr == smic_pkg::CRC_HI_ADDR) ? crc_cnt[15:8] : 8'h00;

  // remote path: forwarded accesses pass whatever the block bit says
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      REM_WR_REJECT <= 1'b0;
      REM_FWD_VALID <= 1'b0;
      REM_FWD_ADDR <= 8'h00;
      REM_FWD_DATA <= 8'h00;
    end else begin
      REM_WR_REJECT <= rem_take & REM_WR_LOCAL & reg_ctrl[smic_pkg::BLOCK_BIT];
      REM_FWD_VALID <= rem_take & ~REM_WR_LOCAL;
      if (rem_take && !REM_WR_LOCAL) begin
        REM_FWD_ADDR <= REM_WR_ADDR;
        REM_FWD_DATA <= REM_WR_DATA;
      end
    end
  end

  // error counter held at zero while the clear bit stays set
  always_ff @(posedge REF_CLK) begin
    if (SRST || reg_mode[smic_pkg::CRC_CLEAR_BIT]) begin
      crc_cnt <= 16'h0000;
    end else if (CRC_ERROR && crc_cnt != 16'hffff) begin
      crc_cnt <= crc_cnt + 16'h0001;
    end
  end

  // mode selection from pin or register override
  wire legacy_eff;
  wire range_eff;
  wire gate_active;
  assign legacy_eff = reg_mode[smic_pkg::LEGACY_SRC_BIT] ? reg_mode[smic_pkg::LEGACY_BIT] : legacy_pin_s;
  assign range_eff = reg_mode[smic_pkg::RANGE_SRC_BIT] ? reg_mode[smic_pkg::RANGE_BIT] : range_pin_s;
  assign gate_active = reg_mode[smic_pkg::GATE_BIT] & (legacy_eff | ~PARTNER_PROTECTED);

  // registered mode outputs and gated pixels
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      FAILSAFE_LOW <= 1'b1;
      LEGACY_MODE <= 1'b0;
      CLOCK_RANGE_LOW <= 1'b0;
      PIXEL_OUT <= 24'h000000;
    end else begin
      FAILSAFE_LOW <= reg_mode[smic_pkg::FAILSAFE_BIT];
      LEGACY_MODE <= legacy_eff;
      CLOCK_RANGE_LOW <= range_eff;
      PIXEL_OUT <= (gate_active && !DATA_ENABLE) ? 24'h000000 : PIXEL_IN;
    end
  end

  // sda delay line; tap picks the nominal scl-to-sda figure
  wire [4:0] sda_tap;
  assign sda_tap = 5'(smic_pkg::DLY_BASE_CYCLES - 2) +
                   5'(reg_ctrl[smic_pkg::DLY_HI_BIT:smic_pkg::DLY_LO_BIT]) * 5'(smic_pkg::DLY_STEP_CYCLES);
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      sda_dly <= '0;
      SDA_OE <= 1'b0;
    end else begin
      sda_dly <= {sda_dly[smic_pkg::DLY_TAPS-2:0], bus.pull};
      SDA_OE <= sda_dly[sda_tap];
    end
  end
  assign SDA_OUT = 1'b0;
  assign SCL_OUT = 1'b0;

  // watchdog; own clearing clocks are not counted as activity
  wire activity;
  wire [25:0] wd_limit;
  wire wd_expire;
  wire half_done;
  assign activity = (scl_s ^ scl_p) | (sda_s ^ sda_p);
  assign wd_limit = reg_ctrl[smic_pkg::SPEED_BIT] ? 26'(smic_pkg::WDOG_FAST_CYCLES) : 26'(WDOG_LONG_CYCLES);
  assign wd_expire = wd_state == smic_pkg::WD_WATCH && !reg_ctrl[smic_pkg::WD_DIS_BIT] &&
                     !activity && wd_cnt == wd_limit - 26'h1;
  assign half_done = half_cnt == 8'(smic_pkg::CLR_HALF_CYCLES - 1);
  assign bus.bus_reset = wd_expire | (wd_state == smic_pkg::WD_CLEAR);

  always_ff @(posedge REF_CLK) begin
    scl_p <= scl_s;
    sda_p <= sda_s;
  end

  // idle counter and nine-pulse bus clearing
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      wd_state <= smic_pkg::WD_WATCH;
      wd_cnt <= 26'h0;
      half_cnt <= 8'h00;
      pulses <= 4'h0;
      SCL_OE <= 1'b0;
      BUS_FREE <= 1'b0;
    end else begin
      BUS_FREE <= wd_expire & sda_s;
      case (wd_state)
        smic_pkg::WD_WATCH: begin
          if (reg_ctrl[smic_pkg::WD_DIS_BIT] || activity || wd_expire) begin
            wd_cnt <= 26'h0;
          end else begin
            wd_cnt <= wd_cnt + 26'h1;
          end
          if (wd_expire && !sda_s) begin
            wd_state <= smic_pkg::WD_CLEAR;
            SCL_OE <= 1'b1;
            half_cnt <= 8'h00;
            pulses <= 4'h0;
          end
        end
        smic_pkg::WD_CLEAR: begin
          half_cnt <= half_done ? 8'h00 : half_cnt + 8'h01;
          if (half_done && SCL_OE) begin
            SCL_OE <= 1'b0;
          end else if (half_done && pulses == 4'(smic_pkg::CLR_PULSES - 1)) begin
            wd_state <= smic_pkg::WD_WATCH;
            wd_cnt <= 26'h0;
          end else if (half_done) begin
            SCL_OE <= 1'b1;
            pulses <= pulses + 4'h1;
          end
        end
        default: begin
          wd_state <= smic_pkg::WD_WATCH;
        end
      endcase
    end
  end

  // checks
  failsafe_follow_a: assert property (wr_mode |-> ##2 FAILSAFE_LOW == $past(wr_data[7], 2))
    else $error("failsafe level does not follow mode bit 7");
  clear_sticky_a: assert property (reg_mode[5] && !wr_mode |=> reg_mode[5])
    else $error("counter clear bit changed without a write");
  count_cleared_a: assert property (reg_mode[5] |=> crc_cnt == 16'h0000)
    else $error("error count not held at zero while clearing");
  pixel_gate_a: assert property (gate_active && !DATA_ENABLE |=> PIXEL_OUT == 24'h000000)
    else $error("pixels not blanked outside data enable");
  pixel_pass_a: assert property (!reg_mode[4] |=> PIXEL_OUT == $past(PIXEL_IN))
    else $error("pixels altered with gating off");
  legacy_pin_a: assert property (!reg_mode[3] |=> LEGACY_MODE == $past(legacy_pin_s))
    else $error("legacy pairing not taken from pin");
  legacy_reg_a: assert property (reg_mode[3] |=> LEGACY_MODE == $past(reg_mode[2]))
    else $error("legacy pairing not taken from register");
  range_pin_a: assert property (!reg_mode[1] |=> CLOCK_RANGE_LOW == $past(range_pin_s))
    else $error("clock range not taken from pin");
  range_reg_a: assert property (reg_mode[1] |=> CLOCK_RANGE_LOW == $past(reg_mode[0]))
    else $error("clock range not taken from register");
  sda_delay_min_a: assert property (reg_ctrl[4:3] == 2'b00 && $past(reg_ctrl[4:3], 12) == 2'b00
    |-> SDA_OE == $past(bus.pull, 12))
    else $error("sda delay at code 00 is not twelve cycles");
  sda_delay_max_a: assert property (reg_ctrl[4:3] == 2'b11 && $past(reg_ctrl[4:3], 18) == 2'b11
    |-> SDA_OE == $past(bus.pull, 18))
    else $error("sda delay at code 11 is not eighteen cycles");
  remote_block_a: assert property (rem_take && REM_WR_LOCAL && reg_ctrl[2] && !bus.wr_stb
    |=> REM_WR_REJECT && $stable(reg_mode) && $stable(reg_ctrl))
    else $error("blocked remote write reached local registers");
  remote_write_a: assert property (rem_take && REM_WR_LOCAL && !reg_ctrl[2]
    && REM_WR_ADDR == smic_pkg::MODE_ADDR |=> reg_mode == ($past(REM_WR_DATA) & smic_pkg::MODE_WMASK))
    else $error("allowed remote write did not reach mode register");
  remote_fwd_a: assert property (rem_take && !REM_WR_LOCAL
    |=> REM_FWD_VALID && REM_FWD_DATA == $past(REM_WR_DATA) && REM_FWD_ADDR == $past(REM_WR_ADDR))
    else $error("forwarded remote write lost or changed");
  fast_timeout_a: assert property (wd_expire && reg_ctrl[1] |-> wd_cnt == 26'(smic_pkg::WDOG_FAST_CYCLES - 1))
    else $error("fast watchdog expired at wrong count");
  bus_free_a: assert property (wd_expire && sda_s |=> BUS_FREE && !SCL_OE)
    else $error("free bus not reported on expiry");
  bus_clear_a: assert property (wd_expire && !sda_s |=> SCL_OE && wd_state == smic_pkg::WD_CLEAR)
    else $error("hung bus clearing did not start");
  clear_count_a: assert property (wd_state == smic_pkg::WD_CLEAR |-> pulses < 4'(smic_pkg::CLR_PULSES))
    else $error("more than nine clearing pulses");
  wd_off_a: assert property (reg_ctrl[0] && $past(reg_ctrl[0]) |-> wd_cnt == 26'h0 && !wd_expire)
    else $error("disabled watchdog still counting");
  reserved_zero_a: assert property (!reg_mode[6] && reg_ctrl[7:5] == 3'b000)
    else $error("reserved bit reads nonzero");
  count_clear_c: cover property (crc_cnt != 16'h0000 ##1 reg_mode[5]);
  gate_blank_c: cover property (gate_active && !DATA_ENABLE && PIXEL_IN != 24'h000000);
  bus_clear_c: cover property (wd_state == smic_pkg::WD_CLEAR ##1 wd_state == smic_pkg::WD_WATCH);
  remote_reject_c: cover property (REM_WR_REJECT);
  bus_free_c: cover property (BUS_FREE);
endmodule : smic_top

// ### verification/serializer_mode_and_i2c_control_tb.sv
// bench for the link mode and serial bus control bank
// assumes the bus master model and a shortened long watchdog of 3000 cycles
`timescale 1ns/100ps
module serializer_mode_and_i2c_control_tb;
  localparam logic [7:0] MA = smic_pkg::MODE_ADDR;
  localparam logic [7:0] CA = smic_pkg::CTRL_ADDR;
  logic REF_CLK = 1'b0;
  logic SRST = 1'b1;
  logic LEGACY_PAIRING_PIN = 1'b0, CLOCK_RANGE_PIN = 1'b0, CRC_ERROR = 1'b0, PARTNER_PROTECTED = 1'b0;
  logic DATA_ENABLE = 1'b0, REM_WR_VALID = 1'b0, REM_WR_LOCAL = 1'b0;
  logic [23:0] PIXEL_IN = 24'h0;
  logic [7:0] REM_WR_ADDR = 8'h0, REM_WR_DATA = 8'h0;
  logic SCL_IN, SDA_IN, SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, BUS_FREE, FAILSAFE_LOW, LEGACY_MODE, CLOCK_RANGE_LOW;
  logic REM_WR_READY, REM_WR_REJECT, REM_FWD_VALID, ok, p;
  logic [23:0] PIXEL_OUT;
  logic [7:0] REM_FWD_ADDR, REM_FWD_DATA;
  int num_errors = 0, n_checks = 0, cycles = 0, n, d3;
  smic_top #(.WDOG_LONG_CYCLES(3000)) uut (
    .REF_CLK(REF_CLK), .SRST(SRST), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .BUS_FREE(BUS_FREE), .LEGACY_PAIRING_PIN(LEGACY_PAIRING_PIN),
    .CLOCK_RANGE_PIN(CLOCK_RANGE_PIN), .FAILSAFE_LOW(FAILSAFE_LOW), .LEGACY_MODE(LEGACY_MODE),
    .CLOCK_RANGE_LOW(CLOCK_RANGE_LOW), .CRC_ERROR(CRC_ERROR), .PARTNER_PROTECTED(PARTNER_PROTECTED),
    .DATA_ENABLE(DATA_ENABLE), .PIXEL_IN(PIXEL_IN), .PIXEL_OUT(PIXEL_OUT), .REM_WR_VALID(REM_WR_VALID),
    .REM_WR_READY(REM_WR_READY), .REM_WR_LOCAL(REM_WR_LOCAL), .REM_WR_ADDR(REM_WR_ADDR),
    .REM_WR_DATA(REM_WR_DATA), .REM_WR_REJECT(REM_WR_REJECT), .REM_FWD_VALID(REM_FWD_VALID),
    .REM_FWD_ADDR(REM_FWD_ADDR), .REM_FWD_DATA(REM_FWD_DATA)
  );
  smic_bus_master m (.clk(REF_CLK), .scl_oe(SCL_OE), .sda_oe(SDA_OE), .scl(SCL_IN), .sda(SDA_IN));
  initial begin
    forever #10 REF_CLK = ~REF_CLK;
  end
  // run should take about 60k cycles, so this only trips on a hang
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic chk_b(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_b
  task automatic chk_v(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_v
  // serial bus access; on a read d is the expected byte
  task automatic acc(input logic rnw, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    m.xfer(rnw, a, d, q, ok);
    chk_b("bus ack", 1'b1, ok);
    if (rnw) chk_v("read byte", {16'h0, d}, {16'h0, q});
  endtask : acc
  // remote write held until ready, released after the taking edge
  task automatic rem(input logic loc, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(negedge REF_CLK);
    REM_WR_VALID = 1'b1;
    REM_WR_LOCAL = loc;
    REM_WR_ADDR = a;
    REM_WR_DATA = d;
    k = 0;
    while (REM_WR_READY !== 1'b1 && k < 50) begin
      @(negedge REF_CLK);
      k++;
    end
    @(negedge REF_CLK);
    REM_WR_VALID = 1'b0;
  endtask : rem
  task automatic wait_free(input int lim);
    n = 0;
    while (BUS_FREE !== 1'b1 && n < lim) begin
      @(negedge REF_CLK);
      n++;
    end
  endtask : wait_free
  initial begin
    repeat (5) @(negedge REF_CLK);
    SRST = 1'b0;
    repeat (4) @(negedge REF_CLK);
    chk_b("failsafe", 1'b1, FAILSAFE_LOW);
    acc(1'b1, MA, 8'h80);
    acc(1'b1, CA, 8'h00);
    m.frame(1'b1, 1'b0);
    m.byte_out(8'h36, ok);
    m.frame(1'b0, 1'b1);
    chk_b("foreign ack", 1'b0, ok);
    acc(1'b0, MA, 8'hff);
    m.half = 60;
    acc(1'b1, MA, 8'hbf);
    m.half = 30;
    acc(1'b0, CA, 8'hf8);
    acc(1'b1, CA, 8'h18);
    d3 = m.addr_dly;
    acc(1'b0, CA, 8'h02);
    wait_free(4000);
    chk_b("fast expiry", 1'b1, n inside {[2450:2500]});
    acc(1'b1, CA, 8'h02);
    chk_v("sda delay step", 24'h6, 24'(d3 - m.addr_dly));
    acc(1'b0, CA, 8'h12);
    acc(1'b1, CA, 8'h12);
    chk_v("sda delay code two", 24'h2, 24'(d3 - m.addr_dly));
    // hang the bus with sda low and count the clearing clocks
    m.m_sda = 1'b0;
    n = 0;
    p = 1'b0;
    repeat (8000) begin
      @(negedge REF_CLK);
      if (SCL_OE === 1'b1 && p !== 1'b1) n++;
      p = SCL_OE;
    end
    m.m_sda = 1'b1;
    chk_v("clear clocks", 24'h9, 24'(n));
    acc(1'b0, CA, 8'h00);
    wait_free(4000);
    chk_b("slow expiry", 1'b1, n inside {[2950:3000]});
    acc(1'b0, CA, 8'h01);
    wait_free(4000);
    chk_b("watchdog off", 1'b1, n == 4000);
    chk_b("no free flag", 1'b0, BUS_FREE);
    acc(1'b0, CA, 8'h00);
    // override bits against pins that always disagree with the register
    for (int i = 0; i < 16; i++) begin
      LEGACY_PAIRING_PIN = ~i[2];
      CLOCK_RANGE_PIN = ~i[0];
      rem(1'b1, MA, {~i[0], 3'b000, i[3:0]});
      repeat (5) @(negedge REF_CLK);
      chk_b("failsafe", ~i[0], FAILSAFE_LOW);
      chk_b("legacy", i[3] ? i[2] : ~i[2], LEGACY_MODE);
      chk_b("range", i[1] ? i[0] : ~i[0], CLOCK_RANGE_LOW);
    end
    for (int j = 0; j < 16; j++) begin
      rem(1'b1, MA, {3'b100, j[0], 1'b1, j[1], 2'b00});
      PARTNER_PROTECTED = j[2];
      DATA_ENABLE = j[3];
      PIXEL_IN = 24'h5a3cc3 ^ 24'(j);
      repeat (3) @(negedge REF_CLK);
      chk_v("pixel", (j[0] & (j[1] | ~j[2]) & ~j[3]) ? 24'h0 : 24'h5a3cc3 ^ 24'(j), PIXEL_OUT);
    end
    CRC_ERROR = 1'b1;
    repeat (300) @(negedge REF_CLK);
    CRC_ERROR = 1'b0;
    acc(1'b1, smic_pkg::CRC_LO_ADDR, 8'h2c);
    acc(1'b1, smic_pkg::CRC_HI_ADDR, 8'h01);
    rem(1'b1, MA, 8'ha0);
    acc(1'b1, MA, 8'ha0);
    rem(1'b1, MA, 8'h80);
    acc(1'b1, smic_pkg::CRC_LO_ADDR, 8'h00);
    acc(1'b0, CA, 8'h04);
    rem(1'b1, MA, 8'h81);
    chk_b("reject", 1'b1, REM_WR_REJECT);
    rem(1'b0, 8'h33, 8'h5a);
    chk_b("forward", 1'b1, REM_FWD_VALID);
    chk_v("forward", 24'h335a, {8'h0, REM_FWD_ADDR, REM_FWD_DATA});
    acc(1'b1, MA, 8'h80);
    chk_b("sda out", 1'b0, SDA_OUT);
    chk_b("scl out", 1'b0, SCL_OUT);
    conclude();
  end
endmodule : serializer_mode_and_i2c_control_tb

// ### verification/smic_bus_master.sv
// serial control bus master model on open-drain lines with pull-ups
// assumes the bench calls one task at a time through the hierarchy
`timescale 1ns/100ps
module smic_bus_master (
  // clock
  input wire logic clk,
  // device pull-downs
  input wire logic scl_oe,
  input wire logic sda_oe,
  // resolved lines
  output logic scl,
  output logic sda
);
  int half = 30;
  int dly;
  int addr_dly;
  logic m_scl = 1'b1;
  logic m_sda = 1'b1;
  // released lines float high through the pull-ups, never hold a stale value
  assign scl = m_scl & ~scl_oe;
  assign sda = m_sda & ~sda_oe;
  // every line change lands just after a falling clock edge
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold
  task automatic bit_out(input logic b);
    m_sda = b;
    hold(half);
    m_scl = 1'b1;
    hold(half);
    m_scl = 1'b0;
  endtask : bit_out
  // low phase also notes when the device first pulls sda
  task automatic bit_in(output logic r);
    m_sda = 1'b1;
    dly = 0;
    for (int k = 1; k <= half; k++) begin
      @(negedge clk);
      if (sda_oe === 1'b1 && dly == 0) dly = k;
    end
    m_scl = 1'b1;
    hold(half / 2);
    r = sda;
    hold(half / 2);
    m_scl = 1'b0;
  endtask : bit_in
  // sda moves while scl is high: falling starts a frame, rising stops it
  task automatic frame(input logic from, input logic to);
    m_sda = from;
    hold(half);
    m_scl = 1'b1;
    hold(half);
    m_sda = to;
    hold(half);
    m_scl = to;
  endtask : frame
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(r);
    ack = ~r;
  endtask : byte_out
  // pointer write, then either one data byte or a repeated start and one read byte
  task automatic xfer(input logic rnw, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
                      output logic ok);
    logic [2:0] k;
    frame(1'b1, 1'b0);
    byte_out({smic_pkg::DEV_ADDR, 1'b0}, k[0]);
    addr_dly = dly;
    byte_out(a, k[1]);
    if (rnw) begin
      frame(1'b1, 1'b0);
      byte_out({smic_pkg::DEV_ADDR, 1'b1}, k[2]);
      addr_dly = dly;
      for (int i = 7; i >= 0; i--) bit_in(q[i]);
      bit_out(1'b1);
    end else begin
      byte_out(d, k[2]);
    end
    frame(1'b0, 1'b1);
    ok = &k;
  endtask : xfer
endmodule : smic_bus_master
